/* File: shared/seg_event_pkg.sv */
// Shared constants and carrier types for the segment time and local event block
package seg_event_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int unsigned CLOCK_HZ         = 100_000_000;
  localparam int unsigned TICK_PERIOD_MS   = 1000;
  localparam int unsigned TICK_CYCLES      = CLOCK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned SECONDS_PER_MIN  = 60;

  // ****************************************
  // Event counts and widths
  // ****************************************
  localparam int unsigned NUM_TIME_EVENTS  = 4;
  localparam int unsigned NUM_LOCAL_EVENTS = 2;
  localparam int unsigned SEG_INDEX_W      = 5;
  localparam int unsigned NUM_SEGMENTS     = 32;
  localparam int unsigned TIME_W           = 17;
  localparam int unsigned VALUE_W          = 16;

  // Event time encoding: minutes/seconds field packed as hundreds.fraction
  localparam logic [TIME_W-1:0] TIME_UNREGISTERED = 17'h0_0000;
  localparam logic [TIME_W-1:0] TIME_MAX_UNITS    = 17'h0_EA5F;
  localparam int unsigned       TIME_MAX_WHOLE    = 999;
  localparam int unsigned       TIME_MAX_FRAC     = 59;

  // ****************************************
  // Program time unit
  // ****************************************
  localparam logic UNIT_HOUR_MIN = 1'b0;
  localparam logic UNIT_MIN_SEC  = 1'b1;

  // ****************************************
  // Local event type codes
  // ****************************************
  localparam logic [7:0] LTYPE_OFF        = 8'h00;
  localparam logic [7:0] LTYPE_FIRST      = 8'h01;
  localparam logic [7:0] LTYPE_LAST       = 8'h12;
  localparam logic [7:0] LTYPE_DEENERGY   = 8'h64;
  localparam logic [7:0] LTYPE_DE_FIRST   = 8'h65;
  localparam logic [7:0] LTYPE_DE_LAST    = 8'h76;
  localparam logic [VALUE_W-1:0] SETPOINT_MAX = 16'h7530;
  localparam logic [9:0] HYST_MAX_PERMIL  = 10'h3E8;
  localparam logic [9:0] PERMIL_FULL      = 10'h3E8;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_RESET   = 4'b0001,
    MODE_PROGRAM = 4'b0010,
    MODE_LOCAL   = 4'b0100,
    MODE_OTHER   = 4'b1000
  } op_mode_type;

  // ****************************************
  // Carrier structs
  // ****************************************
  typedef struct packed {
    logic              initial_on;
    logic [TIME_W-1:0] on_time;
    logic [TIME_W-1:0] off_time;
  } time_event_cfg_type;

  typedef struct packed {
    logic signed [VALUE_W-1:0] pv;
    logic signed [VALUE_W-1:0] sp;
    logic signed [VALUE_W-1:0] target_sp;
    logic signed [VALUE_W-1:0] out;
    logic signed [VALUE_W-1:0] cool_out;
    logic        [VALUE_W-1:0] input_span;
    logic        [VALUE_W-1:0] output_span;
  } process_values_type;

  typedef struct packed {
    logic        [7:0]         type_code;
    logic signed [VALUE_W-1:0] setpoint;
    logic        [9:0]         hyst_permil;
  } local_event_cfg_type;

endpackage

/* File: test/relay_contact_bank.sv */
// Relay contact bank standing on the event outputs
`timescale 1ns/1ps
module relay_contact_bank #(
  parameter int unsigned N = 6
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  // Coils and contacts
  input  wire logic [N-1:0] coil_i,
  output logic      [N-1:0] contact_o
);
  // Armature lags the coil by one cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      contact_o <= '0;
    end else begin
      contact_o <= coil_i;
    end
  end
endmodule

/* File: test/seg_event_monitor.sv */
// Concurrent checks on the segment time and local event ports
`timescale 1ns/1ps
module seg_event_monitor
  import seg_event_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic                        clock_i,
  input wire logic                        rst_i,
  // Program side
  input wire logic                        program_time_unit_i,
  input wire op_mode_type                 op_mode_i,
  input wire logic                        seg_start_i,
  input wire logic                        start_code_ramp_i,
  input wire logic [TIME_W-1:0]           start_offset_i,
  input wire local_event_cfg_type         local_cfg0_i,
  // Outputs
  input wire logic [NUM_TIME_EVENTS-1:0]  time_event_o,
  input wire logic [NUM_LOCAL_EVENTS-1:0] local_event_o,
  input wire logic [TIME_W-1:0]           elapsed_o
);
  logic [10:0]       quiet_q;
  logic [10:0]       gap_q;
  logic [TIME_W-1:0] prev_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ****
  // Helpers
  // ****
  // Quiet span keeps start loads and mode changes out of the tick checks
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_q <= '0;
      gap_q   <= '0;
      prev_q  <= '0;
    end else begin
      prev_q <= elapsed_o;
      gap_q  <= (elapsed_o != prev_q) ? 11'h001 : ((gap_q == '1) ? gap_q : gap_q + 11'h001);
      if (seg_start_i || op_mode_i != MODE_PROGRAM || $changed(program_time_unit_i)) begin
        quiet_q <= '0;
      end else if (quiet_q != '1) begin
        quiet_q <= quiet_q + 11'h001;
      end
    end
  end
  a_mode_clears: assert property (op_mode_i != MODE_PROGRAM |=> time_event_o == '0)
    else $error("time event on outside program mode");
  a_local_idle: assert property (op_mode_i != MODE_LOCAL |=> local_event_o == '0)
    else $error("local event on outside local mode");
  a_type_off: assert property (local_cfg0_i.type_code == LTYPE_OFF |=> !local_event_o[0])
    else $error("disabled local event active");
  a_reset_clear: assert property ($past(rst_i) && !rst_i |-> time_event_o == '0
    && local_event_o == '0 && elapsed_o == '0) else $error("outputs set after reset");
  a_elapsed_step: assert property (quiet_q > 11'h005 && elapsed_o != prev_q
    |-> elapsed_o == prev_q + 17'h0_0001) else $error("elapsed jumped");
  a_tick_gap: assert property (quiet_q > gap_q + 11'h005 && elapsed_o != prev_q
    |-> gap_q == TICK_DIV * (program_time_unit_i ? 1 : 60)) else $error("tick spacing wrong");
  a_change_cause: assert property (quiet_q > 11'h005 && $changed(time_event_o)
    |-> $past(elapsed_o) != $past(elapsed_o, 2)) else $error("event moved without tick");
  a_start_load: assert property ($rose(seg_start_i) && !start_code_ramp_i
    && op_mode_i == MODE_PROGRAM |-> ##[2:5] elapsed_o == '0) else $error("timer not restarted");
  a_ramp_load: assert property ($rose(seg_start_i) && start_code_ramp_i
    && op_mode_i == MODE_PROGRAM |-> ##[2:5] elapsed_o == start_offset_i / 100 * 60
    + start_offset_i % 100) else $error("ramp entry time wrong");
  c_ramp: cover property ($rose(seg_start_i) && start_code_ramp_i);
  c_local: cover property (local_event_o == 2'h3);
  c_all_on: cover property (time_event_o == 4'hf);
endmodule

bind segment_time_events seg_event_monitor #(.TICK_DIV(TICK_DIV)) mon (
  .clock_i(clock_i), .rst_i(rst_i), .program_time_unit_i(program_time_unit_i),
  .op_mode_i(op_mode_i), .seg_start_i(seg_start_i), .start_code_ramp_i(start_code_ramp_i),
  .start_offset_i(start_offset_i), .local_cfg0_i(local_cfg0_i), .time_event_o(time_event_o),
  .local_event_o(local_event_o), .elapsed_o(elapsed_o));

/* File: test/segment_time_events_tb_top.sv */
// Self-checking bench for the segment time and local event block
`timescale 1ns/1ps
module segment_time_events_tb_top;
  import seg_event_pkg::*;
  logic                   clock_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cfg_we_i = 1'b0;
  logic [SEG_INDEX_W-1:0] cfg_seg_i = '0;
  logic [1:0]             cfg_event_i = '0;
  time_event_cfg_type     cfg_data_i = '0;
  logic                   program_time_unit_i = UNIT_MIN_SEC;
  op_mode_type            op_mode_i = MODE_RESET;
  logic                   seg_start_i = 1'b0;
  logic [SEG_INDEX_W-1:0] seg_index_i = '0;
  logic [TIME_W-1:0]      seg_duration_i = '0;
  logic                   start_code_ramp_i = 1'b0;
  logic [TIME_W-1:0]      start_offset_i = '0;
  local_event_cfg_type    local_cfg0_i = '0;
  local_event_cfg_type    local_cfg1_i = '0;
  process_values_type     process_i = '0;
  logic [3:0]             time_event_o;
  logic [1:0]             local_event_o;
  logic [TIME_W-1:0]      elapsed_o;
  time_event_cfg_type     cm [128];
  op_mode_type            md [3] = '{MODE_RESET, MODE_LOCAL, MODE_OTHER};
  int                     n_fail = 0;
  int                     checked = 0;
  always #5 clock_i = ~clock_i;
  segment_time_events #(.TICK_DIV(10)) dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .cfg_we_i(cfg_we_i), .cfg_seg_i(cfg_seg_i), .cfg_event_i(cfg_event_i),
    .cfg_data_i(cfg_data_i), .program_time_unit_i(program_time_unit_i), .op_mode_i(op_mode_i),
    .seg_start_i(seg_start_i), .seg_index_i(seg_index_i), .seg_duration_i(seg_duration_i),
    .start_code_ramp_i(start_code_ramp_i), .start_offset_i(start_offset_i),
    .local_cfg0_i(local_cfg0_i), .local_cfg1_i(local_cfg1_i), .process_i(process_i),
    .time_event_o(time_event_o), .local_event_o(local_event_o), .elapsed_o(elapsed_o));
  relay_contact_bank relays (.clock_i(clock_i), .rst_i(rst_i),
    .coil_i({local_event_o, time_event_o}), .contact_o());
  // ****
  // Expectations
  // ****
  // Off is applied after on, so a tie ends off
  function automatic logic exp_ev(input time_event_cfg_type c, input int t, input int dur);
    logic s;
    s = c.initial_on;
    for (int k = 1; k <= t; k++) begin
      if (c.on_time == k && k <= dur) s = 1'b1;
      if (c.off_time == k && k <= dur) s = 1'b0;
    end
    return s;
  endfunction
  function automatic logic exp_loc(input local_event_cfg_type c, input process_values_type p);
    int q;
    int n;
    logic a;
    n = (c.type_code > 100) ? c.type_code - 100 : c.type_code;
    case (n)
      1, 2: q = p.pv;
      3, 4: q = p.sp;
      5, 6, 7, 8: q = p.pv - p.sp;
      9, 10: q = p.target_sp;
      11, 12, 13, 14: q = p.pv - p.target_sp;
      15, 16: q = p.out;
      17, 18: q = p.cool_out;
      default: return 1'b0;
    endcase
    if ((n == 7 || n == 8 || n == 13 || n == 14) && q < 0) q = -q;
    if (n == 8 || n == 14) a = q < c.setpoint;
    else if (n % 2) a = q > c.setpoint;
    else a = q < c.setpoint;
    return (c.type_code > 100) ? !a : a;
  endfunction
  // Even values against an odd setpoint never tie
  function automatic logic [15:0] rv(input int odd);
    return 16'($urandom_range(0, 2000) * 2 - 2000 + odd);
  endfunction
  task automatic report(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_time(input logic [3:0] got, input logic [3:0] exp);
    report(got, exp);
  endtask
  task automatic cmp_local(input logic [1:0] got, input logic [1:0] exp);
    report({2'b00, got}, {2'b00, exp});
  endtask
  task automatic wr(input int s, input int e, input time_event_cfg_type c);
    @(posedge clock_i);
    cfg_we_i <= 1'b1;
    cfg_seg_i <= SEG_INDEX_W'(s);
    cfg_event_i <= 2'(e);
    cfg_data_i <= c;
    cm[s * 4 + e] = c;
  endtask
  task automatic run_seg(input int s, input int dur, input logic ramp, input int ofs);
    int i;
    logic [3:0] x;
    @(posedge clock_i);
    cfg_we_i <= 1'b0;
    seg_index_i <= SEG_INDEX_W'(s);
    seg_duration_i <= TIME_W'(dur);
    start_code_ramp_i <= ramp;
    start_offset_i <= TIME_W'(ofs);
    seg_start_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    seg_start_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    for (int t = ramp ? ofs : 0; t <= dur; t++) begin
      for (i = 0; i < 2000 && elapsed_o !== TIME_W'(t); i++) @(posedge clock_i) #1;
      if (i == 2000) n_fail++;
      repeat (2) @(posedge clock_i);
      #1;
      for (int e = 0; e < 4; e++) x[e] = exp_ev(cm[s * 4 + e], t, dur);
      cmp_time(time_event_o, x);
    end
  endtask
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    n_fail++;
    results();
  end
  initial begin
    time_event_cfg_type c;
    local_event_cfg_type l0;
    local_event_cfg_type l1;
    process_values_type p;
    int sl [4];
    int code;
    logic [1:0] x;
    void'($urandom(32'h1bc3_5afe));
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    op_mode_i <= MODE_PROGRAM;
    // Segments written first, then run, so each must keep its own set
    for (int r = 0; r < 4; r++) begin
      sl[r] = r * 8 + $urandom_range(0, 7);
      for (int e = 0; e < 4; e++) begin
        c = '{1'($urandom), TIME_W'($urandom_range(0, 12)), TIME_W'($urandom_range(0, 12))};
        if (r == 0 && e == 2) c = '{1'b0, 17'h0_0005, 17'h0_0005};
        wr(sl[r], e, c);
      end
    end
    foreach (sl[r]) run_seg(sl[r], 10, 1'b0, 0);
    run_seg(sl[1], 10, 1'b1, $urandom_range(1, 9));
    wr(sl[2], 0, '{1'b0, 17'h0_0001, 17'h0_0003});
    @(posedge clock_i);
    program_time_unit_i <= UNIT_HOUR_MIN;
    run_seg(sl[2], 2, 1'b0, 0);
    @(posedge clock_i);
    program_time_unit_i <= UNIT_MIN_SEC;
    for (int e = 0; e < 4; e++) wr(0, e, '{1'b1, 17'h0_0000, 17'h0_0000});
    foreach (md[j]) begin
      run_seg(0, 2, 1'b0, 0);
      @(posedge clock_i);
      op_mode_i <= md[j];
      repeat (2) @(posedge clock_i);
      #1;
      cmp_time(time_event_o, 4'h0);
      @(posedge clock_i);
      op_mode_i <= MODE_PROGRAM;
    end
    // Every type code, plain and de-energized, then one pass outside local mode
    for (int k = 0; k < 38; k++) begin
      code = (k < 19) ? k : k + 82;
      l0 = '{8'(code), rv(1), 10'h000};
      l1 = '{8'($urandom_range(1, 18) + 100 * $urandom_range(0, 1)), rv(1), 10'h000};
      p = '{rv(0), rv(0), rv(0), rv(0), rv(0), 16'h0100, 16'h0100};
      @(posedge clock_i);
      op_mode_i <= (k == 37) ? MODE_PROGRAM : MODE_LOCAL;
      local_cfg0_i <= l0;
      local_cfg1_i <= l1;
      process_i <= p;
      repeat (3) @(posedge clock_i);
      #1;
      x = (k == 37) ? 2'b00 : {exp_loc(l1, p), exp_loc(l0, p)};
      cmp_local(local_event_o, x);
    end
    results();
  end
endmodule

/* File: verilog/local_event_cmp.sv */
// Alarm-style compare with hysteresis for one local event
`timescale 1ns/1ps
module local_event_cmp
  import seg_event_pkg::*;
(
  // Inputs
  input  wire local_event_cfg_type cfg_i,
  input  wire process_values_type  pv_i,
  input  wire logic                prev_alarm_i,
  // Results
  output logic                     alarm_o,
  output logic                     energized_o
);

  logic        [7:0]         base;
  logic signed [VALUE_W+1:0] val;
  logic signed [VALUE_W+1:0] sp;
  logic signed [VALUE_W+1:0] hy;
  logic        [27:0]        prod;
  logic                      use_out;

  always_comb begin
    base        = cfg_i.type_code;
    energized_o = 1'b1;
    if (cfg_i.type_code >= LTYPE_DE_FIRST && cfg_i.type_code <= LTYPE_DE_LAST) begin
      base        = cfg_i.type_code - LTYPE_DEENERGY;
      energized_o = 1'b0;
    end
    use_out = (base >= 8'h0F);
    prod = (use_out ? pv_i.output_span : pv_i.input_span) * cfg_i.hyst_permil;
    hy   = (VALUE_W+2)'(prod / 28'(PERMIL_FULL));
    sp   = (cfg_i.setpoint > $signed(SETPOINT_MAX)) ? $signed({2'b00, SETPOINT_MAX})
                                                    : (VALUE_W+2)'(cfg_i.setpoint);
    case (base)
      8'h01, 8'h02:                 val = (VALUE_W+2)'(pv_i.pv);
      8'h03, 8'h04:                 val = (VALUE_W+2)'(pv_i.sp);
      8'h05, 8'h06, 8'h07, 8'h08:   val = (VALUE_W+2)'(pv_i.pv) - (VALUE_W+2)'(pv_i.sp);
      8'h09, 8'h0A:                 val = (VALUE_W+2)'(pv_i.target_sp);
      8'h0B, 8'h0C, 8'h0D, 8'h0E:   val = (VALUE_W+2)'(pv_i.pv) - (VALUE_W+2)'(pv_i.target_sp);
      8'h0F, 8'h10:                 val = (VALUE_W+2)'(pv_i.out);
      default:                      val = (VALUE_W+2)'(pv_i.cool_out);
    endcase
    case (base)
      8'h01, 8'h03, 8'h05, 8'h09, 8'h0B, 8'h0F, 8'h11: begin
        alarm_o = prev_alarm_i ? (val > sp - hy) : (val > sp);
      end
      8'h02, 8'h04, 8'h06, 8'h0A, 8'h0C, 8'h10, 8'h12: begin
        alarm_o = prev_alarm_i ? (val < sp + hy) : (val < sp);
      end
      8'h07, 8'h0D: begin
        alarm_o = prev_alarm_i ? (val > sp - hy || -val > sp - hy) : (val > sp || -val > sp);
      end
      8'h08, 8'h0E: begin
        alarm_o = prev_alarm_i ? (val <= sp + hy && -val <= sp + hy) : (val <= sp && -val <= sp);
      end
      default: begin
        alarm_o = 1'b0;
      end
    endcase
  end

endmodule

/* File: verilog/seg_tick_gen.sv */
// Program time tick generator for seconds or minutes
`timescale 1ns/1ps
module seg_tick_gen
  import seg_event_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic clk_en_i,
  // Control
  input  wire logic restart_i,
  input  wire logic unit_i,
  // Tick out
  output logic      tick_o
);

  typedef struct packed {
    logic [31:0] div;
    logic [5:0]  sec;
    logic        tick;
  } tick_state_type;

  tick_state_type s_q;
  tick_state_type s_d;

  // ****************************************
  // Divider
  // ****************************************
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (restart_i) begin
      s_d.div = '0;
      s_d.sec = '0;
    end else if (s_q.div == 32'(TICK_DIV - 1)) begin
      s_d.div = '0;
      // Shared unit picks the least count
      // Hour units need sixty seconds per least count
      if (unit_i == UNIT_MIN_SEC) begin
        s_d.tick = 1'b1;
      end else if (s_q.sec == 6'(SECONDS_PER_MIN - 1)) begin
        s_d.sec  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.sec = s_q.sec + 6'h01;
      end
    end else begin
      s_d.div = s_q.div + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

/* File: verilog/segment_time_events.sv */
// Segment time events and local event outputs
`timescale 1ns/1ps
// Summary of operation
// - Each segment start restarts the timer and an event turns on when elapsed time reaches its on time.
// - An on or off time beyond the segment length never acts in that segment.
// - The state carried into the next segment comes from that segment's start condition.
// - Every segment keeps its own start condition, on time and off time, and the active one applies.
// - Time events are forced off at program end, local start, during reset and outside program mode.
// - A ramp-prioritized entry mid-segment sets each event as if the segment had run from its start.
// - Each of four time events has a start-on or start-off condition.
// - On and off times are either unregistered, disabling the edge, or a time from 0.01 to 999.59.
// - One instrument-wide unit selects hour.minute or minute.second for all event times.
// - Equal on and off times in one segment resolve to off.
// - Local events act only in local operation and are inactive elsewhere.
// - Local outputs follow their compare directly with no stand-by and no latch.
// - Local type codes 1 to 18 pick high, low, band or in-band compares of the process quantities.
// - Adding 100 to a type code gives the same compare with de-energized polarity.
// - Each local setpoint is in display units and limited to at most 30000.
// - Hysteresis is a span percentage from 0.0 to 100.0 applied before an output returns.
module segment_time_events
  import seg_event_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned SEGMENTS = NUM_SEGMENTS
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_en_i,
  // Configuration write port
  input  wire logic                  cfg_we_i,
  input  wire logic [SEG_INDEX_W-1:0] cfg_seg_i,
  input  wire logic [1:0]            cfg_event_i,
  input  wire time_event_cfg_type    cfg_data_i,
  input  wire logic                  program_time_unit_i,
  // Program sequencing
  input  wire op_mode_type           op_mode_i,
  input  wire logic                  seg_start_i,
  input  wire logic [SEG_INDEX_W-1:0] seg_index_i,
  input  wire logic [TIME_W-1:0]     seg_duration_i,
  input  wire logic                  start_code_ramp_i,
  input  wire logic [TIME_W-1:0]     start_offset_i,
  // Local events
  input  wire local_event_cfg_type   local_cfg0_i,
  input  wire local_event_cfg_type   local_cfg1_i,
  input  wire process_values_type    process_i,
  // Outputs
  output logic [NUM_TIME_EVENTS-1:0]  time_event_o,
  output logic [NUM_LOCAL_EVENTS-1:0] local_event_o,
  output logic [TIME_W-1:0]           elapsed_o
);

  // ****************************************
  // Per-segment configuration store
  // ****************************************
  // Per-segment settings
  time_event_cfg_type cfg_mem [SEGMENTS][NUM_TIME_EVENTS];
  time_event_cfg_type cfg_now [NUM_TIME_EVENTS];

  always_ff @(posedge clock_i) begin
    if (clk_en_i && cfg_we_i) begin
      cfg_mem[cfg_seg_i][cfg_event_i] <= cfg_data_i;
    end
  end

  typedef struct packed {
    logic [SEG_INDEX_W-1:0]      seg;
    logic [TIME_W-1:0]           elapsed;
    logic [TIME_W-1:0]           duration;
    logic                        running;
    logic                        pending_start;
    logic                        catchup;
    logic [NUM_TIME_EVENTS-1:0]  tev;
    logic [NUM_LOCAL_EVENTS-1:0] lal;
    logic [NUM_LOCAL_EVENTS-1:0] lout;
    op_mode_type                 mode;
  } state_type;

  state_type s_q;
  state_type s_d;

  // ****************************************
  // Synchronise the segment start input
  // ****************************************
  logic [1:0] start_sync_q;
  logic       start_seen_q;
  logic       start_pulse;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      start_sync_q <= 2'b00;
      start_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      start_sync_q <= {start_sync_q[0], seg_start_i};
      start_seen_q <= start_sync_q[1];
    end
  end

  assign start_pulse = start_sync_q[1] & ~start_seen_q;

  // ****************************************
  // Tick generator
  // ****************************************
  logic tick;

  seg_tick_gen #(
    .TICK_DIV (TICK_DIV)
  ) u_tick (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .restart_i (start_pulse),
    .unit_i    (program_time_unit_i),
    .tick_o    (tick)
  );

  // ****************************************
  // Time conversion
  // ****************************************
  // Whole.fraction entry to least counts; fraction is 0..59
  function automatic logic [TIME_W-1:0] to_units(input logic [TIME_W-1:0] t);
    logic [TIME_W-1:0] whole;
    logic [TIME_W-1:0] frac;
    whole    = t / 17'd100;
    frac     = t % 17'd100;
    to_units = TIME_W'(whole * 17'd60 + frac);
  endfunction

  // Unregistered or out-of-range values disable the edge
  function automatic logic valid_time(input logic [TIME_W-1:0] t);
    valid_time = (t != TIME_UNREGISTERED) && (t % 17'd100 <= 17'(TIME_MAX_FRAC))
                 && (t / 17'd100 <= 17'(TIME_MAX_WHOLE));
  endfunction

  logic [NUM_TIME_EVENTS-1:0] on_hit;
  logic [NUM_TIME_EVENTS-1:0] off_hit;
  logic [NUM_TIME_EVENTS-1:0] on_past;
  logic [NUM_TIME_EVENTS-1:0] off_past;
  logic [NUM_TIME_EVENTS-1:0] replay;

  // ****************************************
  // Per-event compare
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIME_EVENTS; gi++) begin : g_tev
      logic [TIME_W-1:0] on_u;
      logic [TIME_W-1:0] off_u;
      logic              on_ok;
      logic              off_ok;
      assign cfg_now[gi] = cfg_mem[s_q.seg][gi];
      assign on_u   = to_units(cfg_now[gi].on_time);
      assign off_u  = to_units(cfg_now[gi].off_time);
      assign on_ok  = valid_time(cfg_now[gi].on_time) && (on_u <= s_q.duration);
      assign off_ok = valid_time(cfg_now[gi].off_time) && (off_u <= s_q.duration);
      assign on_hit[gi]   = on_ok && (s_q.elapsed == on_u);
      assign off_hit[gi]  = off_ok && (s_q.elapsed == off_u);
      assign on_past[gi]  = on_ok && (on_u <= s_q.elapsed);
      assign off_past[gi] = off_ok && (off_u <= s_q.elapsed);
      // State as if run from start; later edge wins, off on a tie
      assign replay[gi] = (on_past[gi] && off_past[gi]) ? (on_u > off_u)
                        : on_past[gi] ? 1'b1
                        : off_past[gi] ? 1'b0
                        : cfg_now[gi].initial_on;
    end
  endgenerate

  // ****************************************
  // Local event compares
  // ****************************************
  logic [NUM_LOCAL_EVENTS-1:0] l_alarm;
  logic [NUM_LOCAL_EVENTS-1:0] l_energ;
  local_event_cfg_type         l_cfg [NUM_LOCAL_EVENTS];

  assign l_cfg[0] = local_cfg0_i;
  assign l_cfg[1] = local_cfg1_i;

  generate
    for (gi = 0; gi < NUM_LOCAL_EVENTS; gi++) begin : g_lev
      local_event_cmp u_cmp (
        .cfg_i        (l_cfg[gi]),
        .pv_i         (process_i),
        .prev_alarm_i (s_q.lal[gi]),
        .alarm_o      (l_alarm[gi]),
        .energized_o  (l_energ[gi])
      );
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d      = s_q;
    s_d.mode = op_mode_i;
    if (start_pulse) begin
      s_d.seg           = seg_index_i;
      s_d.duration      = to_units(seg_duration_i);
      s_d.running       = 1'b1;
      s_d.pending_start = 1'b1;
      s_d.catchup       = start_code_ramp_i;
      s_d.elapsed       = start_code_ramp_i ? to_units(start_offset_i) : '0;
    end else if (s_q.pending_start) begin
      // Config for the new segment is read one cycle after the index lands
      s_d.pending_start = 1'b0;
      s_d.catchup       = 1'b0;
      for (int i = 0; i < NUM_TIME_EVENTS; i++) begin
        s_d.tev[i] = s_q.catchup ? replay[i] : cfg_now[i].initial_on;
      end
    end else if (s_q.running) begin
      for (int i = 0; i < NUM_TIME_EVENTS; i++) begin
        if (off_hit[i]) begin
          s_d.tev[i] = 1'b0;
        end else if (on_hit[i]) begin
          s_d.tev[i] = 1'b1;
        end
      end
      if (tick && s_q.elapsed < s_q.duration) begin
        s_d.elapsed = s_q.elapsed + 17'h0_0001;
      end
    end
    if (op_mode_i != MODE_PROGRAM) begin
      s_d.tev     = '0;
      s_d.running = 1'b0;
    end
    for (int i = 0; i < NUM_LOCAL_EVENTS; i++) begin
      if (op_mode_i == MODE_LOCAL && l_cfg[i].type_code != LTYPE_OFF) begin
        s_d.lal[i]  = l_alarm[i];
        s_d.lout[i] = l_alarm[i] ~^ l_energ[i];
      end else begin
        s_d.lal[i]  = 1'b0;
        s_d.lout[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_q      <= '0;
      s_q.mode <= MODE_RESET;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign time_event_o  = s_q.tev;
  assign local_event_o = s_q.lout;
  assign elapsed_o     = s_q.elapsed;

endmodule
